// *** design/ssm_top.sv ***
// Purpose: synchronous half-duplex serial port, master or slave, behind a Wishbone slave
// Assumes: pins and far-end clock are asynchronous and pass two flip-flops first
// Notes:   clock line idles low; leading edge rising, trailing edge falling; lsb first
// Notes on behaviour
// - master receive turns off the data line driver
// - master reception starts when either single or continuous receive enable is set
// - single receive clocks exactly one character then clears its own enable
// - continuous receive keeps clocking characters until its enable is cleared or overrun sets
// - clearing continuous enable mid character stops the clock and drops the part
// - both enables set: single clears after first character, continuous goes on
// - data sampled on trailing clock edge and shifted into receive shift register
// - complete character moves into two-entry fifo and sets receive pending flag
// - fifo top shows oldest unread low byte; pending stays while unread remain
// - slave turns off clock line driver and takes clock from far end
// - data changes on leading edge, valid at trailing edge, one bit per cycle
// - third character with full fifo sets overrun, keeps both, accepts no more
// - overrun clears by fifo read in single mode or by clearing continuous enable
// - clearing port enable resets the unit and clears a pending overrun
// - nine-bit receive shifts nine bits; ninth bit shows msb of oldest entry
// - master drives clock line, one cycle per data bit, no extra cycles
// - holding byte waits while shifting, moves once shift register empty, then shifts
// - transmit buffer empty flag sets when holding byte moves to shift register
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`include "ssm_cfg.svh"

module ssm_top #(
  parameter int BAUD_W   = 8,
  parameter int PRESC_LO = `SSM_PRESC_LOW_SPEED
) (
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        data_line_in,
  output logic             data_line_out,
  output logic             data_line_oe_out,
  input  wire logic        clock_line_in,
  output logic             clock_line_out,
  output logic             clock_line_oe_out
);

  // three extra bits cover the widest low speed scale
  localparam int CNT_W = BAUD_W + 3;

  if (BAUD_W != 8) begin : g_chk_w
    $error("ssm_top: baud divisor must be 8 bits wide");
  end
  if (PRESC_LO < 1 || PRESC_LO > 8) begin : g_chk_p
    $error("ssm_top: low speed prescale must be 1 to 8");
  end
  // counter must hold the slowest half period
  if ((2 ** BAUD_W) * PRESC_LO > (2 ** CNT_W)) begin : g_chk_cnt
    $error("ssm_top: baud counter too narrow");
  end

  // pin synchronisers; first stage feeds only the second
  logic              dl_meta,    next_dl_meta;
  logic              dl_sync,    next_dl_sync;
  logic              ck_meta,    next_ck_meta;
  logic              ck_sync,    next_ck_sync;
  logic              ck_prev,    next_ck_prev;

  // registers and engine state
  ssm_pkg::ssm_rx_ctl_t rc,         next_rc;
  ssm_pkg::ssm_tx_ctl_t tc,         next_tc;
  ssm_pkg::ssm_state_t  state,      next_state;
  logic [7:0]           int_en,     next_int_en;
  logic [BAUD_W-1:0]    divisor,    next_divisor;
  logic [7:0]           hold,       next_hold;
  logic                 hold_full,  next_hold_full;
  logic [8:0]           tx_shift_reg,        next_tsr;
  logic                 tsr_full,   next_tsr_full;
  logic [8:0]           rx_shift_reg,        next_rsr;
  logic [3:0]           bit_cnt,    next_bit_cnt;
  logic [3:0]           char_bits,  next_char_bits;
  logic [CNT_W-1:0]     baud_cnt,   next_baud_cnt;
  logic                 ck_level,   next_ck_level;
  logic                 dout,       next_dout;
  logic [8:0]           fifo [`SSM_FIFO_DEPTH];
  logic [8:0]           next_fifo [`SSM_FIFO_DEPTH];
  logic                 rptr,       next_rptr;
  logic [1:0]           fcount,     next_fcount;
  logic                 ack,        next_ack;
  logic [31:0]          rdata,      next_rdata;

  logic             req;
  logic             wr;
  logic             rd;
  logic             active;
  logic             master;
  logic             rx_mode;
  logic             lead;
  logic             trail;
  logic             tick;
  logic             last_bit;
  logic [CNT_W-1:0] reload;
  logic [8:0]       mux_top;

  // first stage may go metastable; only the second stage reads it
  always_comb begin
    next_dl_meta = data_line_in;
    next_dl_sync = dl_meta;
    next_ck_meta = clock_line_in;
    next_ck_sync = ck_meta;
    next_ck_prev = ck_sync;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dl_meta <= 1'b0;
      dl_sync <= 1'b0;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
    end else if (ce_in) begin
      dl_meta <= next_dl_meta;
      dl_sync <= next_dl_sync;
      ck_meta <= next_ck_meta;
      ck_sync <= next_ck_sync;
      ck_prev <= next_ck_prev;
    end
  end

  assign active  = rc.port_enable && tc.sync_mode_sel;
  assign master  = tc.clock_source_master;
  // slave ignores single receive enable
  assign rx_mode = master ? (rc.single_rx_en || rc.cont_rx_en) : rc.cont_rx_en;
  // low speed stretches each divisor step by the prescale
  assign reload  = tc.high_baud_sel ? CNT_W'(divisor) :
                   CNT_W'((32'(divisor) + 32'd1) * 32'(PRESC_LO) - 32'd1);
  // with high speed select, a divisor of zero gives a one-cycle half period
  assign tick    = (baud_cnt == '0);
  assign lead    = master ? (tick && !ck_level) : (ck_sync && !ck_prev);
  assign trail   = master ? (tick && ck_level) : (!ck_sync && ck_prev);
  assign last_bit = (bit_cnt + 4'h1 == char_bits);
  assign mux_top = fifo[rptr];

  always_comb begin
    next_rc        = rc;
    next_tc        = tc;
    next_state     = state;
    next_int_en    = int_en;
    next_divisor   = divisor;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_tsr       = tx_shift_reg;
    next_tsr_full  = tsr_full;
    next_rsr       = rx_shift_reg;
    next_bit_cnt   = bit_cnt;
    next_char_bits = char_bits;
    next_baud_cnt  = baud_cnt;
    next_ck_level  = ck_level;
    next_dout      = dout;
    next_fifo      = fifo;
    next_rptr      = rptr;
    next_fcount    = fcount;
    next_rdata     = rdata;

    // bus: one request taken per ack; effects land with the ack edge
    req      = wb_cyc_in && wb_stb_in && !ack;
    wr       = req && wb_we_in && wb_sel_in[0];
    rd       = req && !wb_we_in;
    next_ack = req;
    if (rd) begin
      next_rdata = 32'h0000_0000;
      if (wb_adr_in == `SSM_ADR_INT_ENABLE) begin
        next_rdata[7:0] = int_en;
      end else if (wb_adr_in == `SSM_ADR_INT_FLAGS) begin
        next_rdata[`SSM_FLG_RX_PENDING] = (fcount != 2'h0);
        next_rdata[`SSM_FLG_TX_EMPTY]   = !hold_full;
      end else if (wb_adr_in == `SSM_ADR_RX_STATUS) begin
        next_rdata[7:0] = {rc[7:1], (fcount != 2'h0) && mux_top[8]};
      end else if (wb_adr_in == `SSM_ADR_BAUD) begin
        next_rdata[7:0] = divisor;
      end else if (wb_adr_in == `SSM_ADR_TX_STATUS) begin
        next_rdata[7:0] = {tc[7:2], !tsr_full, tc[0]};
      end else if (wb_adr_in == `SSM_ADR_RX_FIFO) begin
        next_rdata[7:0] = (fcount != 2'h0) ? mux_top[7:0] : 8'h00;
      end
    end

    // pop before any push so a full fifo read frees room this cycle
    if (rd && wb_adr_in == `SSM_ADR_RX_FIFO && fcount != 2'h0) begin
      next_rptr   = !rptr;
      next_fcount = fcount - 2'h1;
      if (!rc.cont_rx_en) begin
        next_rc.overrun_flag = 1'b0;
      end
    end
    if (wr && wb_adr_in == `SSM_ADR_RX_STATUS && !wb_dat_in[4]) begin
      next_rc.overrun_flag = 1'b0;
    end

    // holding byte moves into an empty shift register at once
    if (active && tc.tx_enable && hold_full && !tsr_full && !rx_mode) begin
      next_tsr       = {tc.tx_ninth_bit, hold};
      next_tsr_full  = 1'b1;
      next_hold_full = 1'b0;
    end

    if (state != ssm_pkg::SSM_IDLE && master) begin
      next_baud_cnt = tick ? reload : baud_cnt - CNT_W'(1);
    end

    case (state)
      ssm_pkg::SSM_IDLE: begin
        next_ck_level = 1'b0;
        next_bit_cnt  = 4'h0;
        next_baud_cnt = reload;
        if (active && rx_mode && !rc.overrun_flag) begin
          next_state     = ssm_pkg::SSM_RX;
          next_char_bits = rc.nine_bit_rx ? `SSM_BITS_WIDE : `SSM_BITS_NARROW;
        end else if (active && !rx_mode && tc.tx_enable && tsr_full) begin
          next_state     = ssm_pkg::SSM_TX;
          next_char_bits = tc.nine_bit_tx ? `SSM_BITS_WIDE : `SSM_BITS_NARROW;
        end
      end
      ssm_pkg::SSM_TX: begin
        if (!active || !tc.tx_enable || rx_mode) begin
          next_state    = ssm_pkg::SSM_IDLE;
          next_tsr_full = 1'b0;
          next_ck_level = 1'b0;
        end else if (lead) begin
          next_dout     = tx_shift_reg[0];
          next_tsr      = {1'b0, tx_shift_reg[8:1]};
          // a slave keeps its own clock output low
          next_ck_level = master;
        end else if (trail) begin
          next_ck_level = 1'b0;
          next_bit_cnt  = bit_cnt + 4'h1;
          if (last_bit) begin
            next_state    = ssm_pkg::SSM_IDLE;
            next_tsr_full = 1'b0;
          end
        end
      end
      default: begin
        if (!active || !rx_mode) begin
          // partial character dropped, clock stops low at once
          next_state    = ssm_pkg::SSM_IDLE;
          next_ck_level = 1'b0;
        end else if (lead) begin
          // a slave keeps its own clock output low
          next_ck_level = master;
        end else if (trail) begin
          next_ck_level        = 1'b0;
          next_rsr[bit_cnt]    = dl_sync;
          next_bit_cnt         = bit_cnt + 4'h1;
          if (last_bit) begin
            next_state = ssm_pkg::SSM_IDLE;
            if (master) begin
              next_rc.single_rx_en = 1'b0;
            end
            if (next_fcount == 2'(`SSM_FIFO_DEPTH)) begin
              next_rc.overrun_flag = 1'b1;
            end else begin
              next_fifo[next_rptr ^ next_fcount[0]] = {rc.nine_bit_rx && dl_sync,
                                                     rc.nine_bit_rx ? rx_shift_reg[7:0] : {dl_sync, rx_shift_reg[6:0]}};
              next_fcount = next_fcount + 2'h1;
            end
          end
        end
      end
    endcase

    // software writes last: a set by software beats a hardware clear
    if (wr) begin
      if (wb_adr_in == `SSM_ADR_INT_ENABLE) begin
        next_int_en = wb_dat_in[7:0];
      end else if (wb_adr_in == `SSM_ADR_RX_STATUS) begin
        next_rc.port_enable    = wb_dat_in[7];
        next_rc.nine_bit_rx    = wb_dat_in[6];
        next_rc.single_rx_en   = wb_dat_in[5];
        next_rc.cont_rx_en     = wb_dat_in[4];
        next_rc.addr_detect_en = wb_dat_in[3];
      end else if (wb_adr_in == `SSM_ADR_BAUD) begin
        next_divisor = wb_dat_in[BAUD_W-1:0];
      end else if (wb_adr_in == `SSM_ADR_TX_HOLD) begin
        next_hold      = wb_dat_in[7:0];
        next_hold_full = 1'b1;
      end else if (wb_adr_in == `SSM_ADR_TX_STATUS) begin
        next_tc.clock_source_master = wb_dat_in[7];
        next_tc.nine_bit_tx         = wb_dat_in[6];
        next_tc.tx_enable           = wb_dat_in[5];
        next_tc.sync_mode_sel       = wb_dat_in[4];
        next_tc.high_baud_sel       = wb_dat_in[2];
        next_tc.tx_ninth_bit        = wb_dat_in[0];
      end
    end

    // unit held in reset while disabled; holding register survives
    if (!rc.port_enable) begin
      next_state           = ssm_pkg::SSM_IDLE;
      next_rc.overrun_flag = 1'b0;
      next_fcount          = 2'h0;
      next_rptr            = 1'b0;
      next_tsr_full        = 1'b0;
      next_ck_level        = 1'b0;
      next_dout            = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rc        <= ssm_pkg::ssm_rx_ctl_t'(`SSM_RST_RX_STATUS);
      tc        <= '0;
      state     <= ssm_pkg::SSM_IDLE;
      int_en    <= `SSM_RST_INT_ENABLE;
      divisor   <= BAUD_W'(`SSM_RST_BAUD);
      hold      <= `SSM_RST_TX_HOLD;
      hold_full <= 1'b0;
      tx_shift_reg       <= 9'h000;
      tsr_full  <= 1'b0;
      rx_shift_reg       <= 9'h000;
      bit_cnt   <= 4'h0;
      char_bits <= `SSM_BITS_NARROW;
      baud_cnt  <= '0;
      ck_level  <= 1'b0;
      dout      <= 1'b0;
      fifo      <= '{default: 9'h000};
      rptr      <= 1'b0;
      fcount    <= 2'h0;
      ack       <= 1'b0;
      rdata     <= 32'h0000_0000;
    end else if (ce_in) begin
      rc        <= next_rc;
      tc        <= next_tc;
      state     <= next_state;
      int_en    <= next_int_en;
      divisor   <= next_divisor;
      hold      <= next_hold;
      hold_full <= next_hold_full;
      tx_shift_reg       <= next_tsr;
      tsr_full  <= next_tsr_full;
      rx_shift_reg       <= next_rsr;
      bit_cnt   <= next_bit_cnt;
      char_bits <= next_char_bits;
      baud_cnt  <= next_baud_cnt;
      ck_level  <= next_ck_level;
      dout      <= next_dout;
      fifo      <= next_fifo;
      rptr      <= next_rptr;
      fcount    <= next_fcount;
      ack       <= next_ack;
      rdata     <= next_rdata;
    end
  end

  assign wb_ack_out        = ack;
  assign wb_dat_out        = rdata;
  assign clock_line_out    = ck_level;
  assign clock_line_oe_out = active && master;
  // receive mode releases the data line for the far end
  assign data_line_out     = dout;
  assign data_line_oe_out  = active && !rx_mode && tc.tx_enable;

endmodule

// *** shared/ssm_cfg.svh ***
// Purpose: register offsets, field positions, reset values and timing for the sync serial port
// Assumes: 32-bit classic Wishbone, byte addresses, one register per aligned word
// Notes:   data sits in bits 7:0, bits above read as zero
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH

`define SSM_ADR_INT_ENABLE   8'h00
`define SSM_ADR_INT_FLAGS    8'h04
`define SSM_ADR_RX_STATUS    8'h08
`define SSM_ADR_BAUD         8'h0C
`define SSM_ADR_TX_HOLD      8'h10
`define SSM_ADR_TX_STATUS    8'h14
`define SSM_ADR_RX_FIFO      8'h18

`define SSM_RST_INT_ENABLE   8'h00
`define SSM_RST_RX_STATUS    8'h00
`define SSM_RST_BAUD         8'h00
`define SSM_RST_TX_HOLD      8'h00

`define SSM_FLG_RX_PENDING   5
`define SSM_FLG_TX_EMPTY     4

`define SSM_BITS_NARROW      4'h8
`define SSM_BITS_WIDE        4'h9
`define SSM_PRESC_LOW_SPEED  4
`define SSM_FIFO_DEPTH       2

`endif

// *** shared/ssm_pkg.sv ***
// Purpose: types shared by the sync serial port
// Assumes: fields are laid out msb first as software sees them
// Notes:   reserved bits and the framing error bit are carried as constant zero fields
package ssm_pkg;

  typedef enum logic [1:0] {
    SSM_IDLE,
    SSM_TX,
    SSM_RX
  } ssm_state_t;

  // receive status and control, bits 7..0
  typedef struct packed {
    logic port_enable;
    logic nine_bit_rx;
    logic single_rx_en;
    logic cont_rx_en;
    logic addr_detect_en;
    logic frame_err;
    logic overrun_flag;
    logic rx_ninth_bit;
  } ssm_rx_ctl_t;

  // transmit status and control, bits 7..0
  typedef struct packed {
    logic clock_source_master;
    logic nine_bit_tx;
    logic tx_enable;
    logic sync_mode_sel;
    logic unused;
    logic high_baud_sel;
    logic tsr_empty;
    logic tx_ninth_bit;
  } ssm_tx_ctl_t;

endpackage

// *** verification/ssm_far_end.sv ***
// Purpose: far-end synchronous serial device, slave or master
// Assumes: released data line reads high, clock line low
// Notes:   lsb first; its own clock runs only inside frames
`timescale 1ns/100ps
module ssm_far_end (
  input  wire logic link_clk_in,
  input  wire logic link_dat_in,
  output logic      clk_out,
  output logic      clk_oe_out,
  output logic      dat_out,
  output logic      dat_oe_out
);
  logic [8:0] txq[$];
  logic [8:0] rxq[$];
  logic [8:0] tx_w, rx_w;
  int         n = 8;
  int         tx_i = 0;
  int         rx_i = 0;
  int         rises = 0;
  initial {clk_out, clk_oe_out, dat_out, dat_oe_out} = 4'h0;
  // as slave: next bit goes out on the leading edge
  always @(posedge link_clk_in) begin
    rises++;
    if (!clk_oe_out && (tx_i > 0 || txq.size() > 0)) begin
      if (tx_i == 0) tx_w = txq.pop_front();
      dat_out = tx_w[tx_i];
      dat_oe_out = 1'b1;
      tx_i = (tx_i + 1) % n;
    end
  end
  // capture on trailing edge; let go of the line after the hold
  always @(negedge link_clk_in) begin
    rx_w[rx_i] = link_dat_in;
    rx_i++;
    if (rx_i >= n) begin
      rxq.push_back(n == 8 ? {1'b0, rx_w[7:0]} : rx_w);
      rx_i = 0;
    end
    if (tx_i == 0 && !clk_oe_out) dat_oe_out <= #20 1'b0;
  end
  task automatic master_xfer(input int bits, input logic [8:0] w, input logic drv);
    clk_oe_out = 1'b1;
    for (int i = 0; i < bits; i++) begin
      clk_out = 1'b1;
      dat_out = w[i];
      dat_oe_out = drv;
      #62.5;
      clk_out = 1'b0;
      #62.5;
    end
    dat_oe_out = 1'b0;
    clk_oe_out = 1'b0;
  endtask
endmodule

// *** verification/ssm_props.sv ***
// Purpose: port checks for ssm_top
// Assumes: bus writes land at the taking edge
// Notes:   control bits are tracked from bus writes
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module ssm_props #(
  parameter int PRESC_LO = 4
) (
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  input  wire logic        data_line_out,
  input  wire logic        data_line_oe_out,
  input  wire logic        clock_line_out,
  input  wire logic        clock_line_oe_out
);
  logic        take, wr, rd_q, next_rd_q;
  logic [7:0]  rx_c, tx_c, baud, adr_q;
  logic [7:0]  next_rx_c, next_tx_c, next_baud;
  logic [15:0] hi, next_hi, half;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr   = take && wb_we_in && wb_sel_in[0];
  assign half = (16'(baud) + 16'h1) * (tx_c[2] ? 16'h1 : 16'(PRESC_LO));
  always_comb begin
    next_rx_c = (wr && wb_adr_in == `SSM_ADR_RX_STATUS) ? wb_dat_in[7:0] : rx_c;
    next_tx_c = (wr && wb_adr_in == `SSM_ADR_TX_STATUS) ? wb_dat_in[7:0] : tx_c;
    next_baud = (wr && wb_adr_in == `SSM_ADR_BAUD) ? wb_dat_in[7:0] : baud;
    next_hi   = clock_line_out ? hi + 16'h1 : 16'h0;
    next_rd_q = take && !wb_we_in;
  end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {rx_c, tx_c, baud, adr_q, hi, rd_q} <= '0;
    end else begin
      {rx_c, tx_c, baud, adr_q, hi, rd_q} <= {next_rx_c, next_tx_c, next_baud, wb_adr_in, next_hi, next_rd_q};
    end
  end
  a_ack_one: assert property (take |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not one pulse one cycle after request");
  a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_wo_reads_zero: assert property (wb_ack_out && rd_q
      && (adr_q == `SSM_ADR_TX_HOLD || adr_q > `SSM_ADR_RX_FIFO) |-> wb_dat_out == 32'h0)
    else $error("write-only or unmapped read not zero");
  // an abort may cut a high phase short, so skip falls within two cycles of a receive status write
  a_half_period: assert property ($fell(clock_line_out) && $past(rx_c, 2) == rx_c |-> hi == half)
    else $error("clock high phase length wrong");
  a_rise_has_oe: assert property ($rose(clock_line_out) |-> clock_line_oe_out)
    else $error("clock rose without driver");
  a_master_drives: assert property (rx_c[7] && tx_c[7] && tx_c[4] |-> clock_line_oe_out)
    else $error("master not driving clock line");
  a_slave_no_clk: assert property (!tx_c[7] |-> !clock_line_oe_out)
    else $error("slave drives clock line");
  a_rx_no_drive: assert property (rx_c[7] && rx_c[4] |-> !data_line_oe_out)
    else $error("data line driven while receiving");
  a_data_on_lead: assert property (clock_line_oe_out && data_line_oe_out && $changed(data_line_out)
      |-> $rose(clock_line_out))
    else $error("data changed off leading edge");
endmodule

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for ssm_top
// Assumes: far end sits on the shared lines
// Notes:   data line pulled up, clock line pulled down
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module tb_top;
  logic        clock_in, arst_n_in, ce_in;
  logic        wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, v;
  logic        wb_ack_out, data_line_out, data_line_oe_out;
  logic        clock_line_out, clock_line_oe_out;
  logic        p_clk, p_clk_oe, p_dat, p_dat_oe;
  wire         data_line_in, clock_line_in;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc_n = 0;
  int          r0;
  assign data_line_in  = data_line_oe_out ? data_line_out : p_dat_oe ? p_dat : 1'b1;
  assign clock_line_in = clock_line_oe_out ? clock_line_out : p_clk_oe ? p_clk : 1'b0;
  ssm_top i_dut (.clock_in, .arst_n_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .data_line_in, .data_line_out,
    .data_line_oe_out, .clock_line_in, .clock_line_out, .clock_line_oe_out);
  ssm_far_end i_far (.link_clk_in(clock_line_in), .link_dat_in(data_line_in), .clk_out(p_clk),
    .clk_oe_out(p_clk_oe), .dat_out(p_dat), .dat_oe_out(p_dat_oe));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    {wb_cyc_in, wb_stb_in} <= 2'b11;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= {24'h000000, d};
    @(posedge clock_in);
    while (wb_ack_out !== 1'b1) @(posedge clock_in);
    v = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(v, exp);
  endtask
  task automatic poll(input int b, input logic lvl);
    bus(1'b0, `SSM_ADR_RX_STATUS, 8'h00);
    while (v[b] !== lvl) bus(1'b0, `SSM_ADR_RX_STATUS, 8'h00);
  endtask
  task automatic wait_rx(input int k);
    while (i_far.rxq.size() < k) @(posedge clock_in);
  endtask
  task automatic t_regs();
    rd(`SSM_ADR_RX_STATUS, 32'h00);
    rd(`SSM_ADR_TX_STATUS, 32'h02);
    rd(`SSM_ADR_RX_FIFO, 32'h00);
    rd(8'h1C, 32'h00);
    wr(`SSM_ADR_INT_ENABLE, 8'h30);
    rd(`SSM_ADR_INT_ENABLE, 32'h30);
  endtask
  // half period 16 cycles: divisor 15 with high speed select
  task automatic t_mtx();
    wr(`SSM_ADR_BAUD, 8'h0F);
    rd(`SSM_ADR_BAUD, 32'h0F);
    wr(`SSM_ADR_TX_STATUS, 8'hB4);
    wr(`SSM_ADR_RX_STATUS, 8'h80);
    wr(`SSM_ADR_TX_HOLD, 8'hA5);
    wr(`SSM_ADR_TX_HOLD, 8'h3C);
    rd(`SSM_ADR_INT_FLAGS, 32'h00);
    wait_rx(2);
    chk(32'(i_far.rxq[0]), 32'hA5);
    chk(32'(i_far.rxq[1]), 32'h3C);
    rd(`SSM_ADR_INT_FLAGS, 32'h10);
    i_far.rxq.delete();
    i_far.n = 9;
    wr(`SSM_ADR_TX_STATUS, 8'hF5);
    wr(`SSM_ADR_TX_HOLD, 8'h5A);
    wait_rx(1);
    chk(32'(i_far.rxq[0]), 32'h15A);
  endtask
  task automatic t_mrx();
    i_far.n = 8;
    i_far.txq.push_back(9'h0C3);
    r0 = i_far.rises;
    wr(`SSM_ADR_TX_STATUS, 8'h94);
    wr(`SSM_ADR_RX_STATUS, 8'hA0);
    poll(5, 1'b0);
    repeat (100) @(posedge clock_in);
    chk(i_far.rises - r0, 32'd8);
    rd(`SSM_ADR_INT_FLAGS, 32'h30);
    rd(`SSM_ADR_RX_FIFO, 32'hC3);
    rd(`SSM_ADR_INT_FLAGS, 32'h10);
  endtask
  task automatic t_ovr();
    i_far.n = 9;
    i_far.txq = {9'h1A5, 9'h05A, 9'h1FF};
    wr(`SSM_ADR_RX_STATUS, 8'hF0);
    poll(1, 1'b1);
    chk(v, 32'hD3);
    rd(`SSM_ADR_RX_FIFO, 32'hA5);
    rd(`SSM_ADR_RX_STATUS, 32'hD2);
    rd(`SSM_ADR_RX_FIFO, 32'h5A);
    wr(`SSM_ADR_RX_STATUS, 8'hC0);
    r0 = i_far.rises;
    rd(`SSM_ADR_RX_STATUS, 32'hC0);
    repeat (100) @(posedge clock_in);
    chk(i_far.rises - r0, 32'd0);
    r0 = i_far.rises;
    wr(`SSM_ADR_RX_STATUS, 8'h90);
    repeat (100) @(posedge clock_in);
    chk(32'(i_far.rises - r0 > 1), 32'h1);
    wr(`SSM_ADR_RX_STATUS, 8'h80);
    r0 = i_far.rises;
    repeat (100) @(posedge clock_in);
    chk(i_far.rises - r0, 32'd0);
    rd(`SSM_ADR_INT_FLAGS, 32'h10);
  endtask
  task automatic t_slave();
    wr(`SSM_ADR_TX_STATUS, 8'h10);
    wr(`SSM_ADR_RX_STATUS, 8'h90);
    chk(32'(clock_line_oe_out), 32'h0);
    i_far.n = 8;
    i_far.rx_i = 0;
    i_far.master_xfer(8, 9'h096, 1'b1);
    i_far.master_xfer(8, 9'h03B, 1'b1);
    repeat (8) @(posedge clock_in);
    rd(`SSM_ADR_INT_FLAGS, 32'h30);
    rd(`SSM_ADR_RX_FIFO, 32'h96);
    wr(`SSM_ADR_RX_STATUS, 8'h00);
    rd(`SSM_ADR_INT_FLAGS, 32'h10);
    wr(`SSM_ADR_RX_STATUS, 8'h80);
    wr(`SSM_ADR_TX_STATUS, 8'h30);
    i_far.rxq.delete();
    i_far.rx_i = 0;
    wr(`SSM_ADR_TX_HOLD, 8'h69);
    i_far.master_xfer(8, 9'h000, 1'b0);
    repeat (4) @(posedge clock_in);
    chk(32'(i_far.rxq[0]), 32'h69);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {arst_n_in, wb_cyc_in, wb_stb_in, wb_we_in} = 4'h0;
    ce_in = 1'b1;
    wb_sel_in = 4'hF;
    wb_adr_in = 8'h00;
    wb_dat_in = 32'h0;
    repeat (20) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    t_regs();
    t_mtx();
    t_mrx();
    t_ovr();
    t_slave();
    wrap_up();
  end
endmodule
bind ssm_top ssm_props #(.PRESC_LO(PRESC_LO)) i_props (.clock_in, .arst_n_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
  .data_line_out, .data_line_oe_out, .clock_line_out, .clock_line_oe_out);
